// >>> inc/tcp_pkg.sv
// Package for the timer clock-select and prescale block
package tcp_pkg;
    // ==========================================================
    // Register map (byte addresses)
    localparam logic [3:0] TCP_CTRL_OFS = 4'h0;
    localparam logic [3:0] TCP_COUNT_OFS = 4'h4;
    localparam logic [3:0] TCP_STAT_OFS = 4'h8;

    // ==========================================================
    // Control field positions
    localparam int TCP_RUN_BIT = 15;
    localparam int TCP_GATE_BIT = 6;
    localparam int TCP_DIV_LSB = 4;
    localparam int TCP_SYNC_BIT = 2;
    localparam int TCP_SRC_BIT = 1;
    localparam int TCP_STAT_SYNC_MODE_BIT = 0;
    localparam logic [15:0] TCP_CTRL_RESET = 16'h0000;
    localparam logic [15:0] TCP_COUNT_RESET = 16'h0000;

    // ==========================================================
    // Prescale codes and terminal counts
    localparam logic [1:0] TCP_DIV_1 = 2'h0;
    localparam logic [1:0] TCP_DIV_8 = 2'h1;
    localparam logic [1:0] TCP_DIV_64 = 2'h2;
    localparam logic [1:0] TCP_DIV_256 = 2'h3;
    localparam logic [7:0] TCP_LAST_1 = 8'h00;
    localparam logic [7:0] TCP_LAST_8 = 8'h07;
    localparam logic [7:0] TCP_LAST_64 = 8'h3F;
    localparam logic [7:0] TCP_LAST_256 = 8'hFF;

    // ==========================================================
    // Types
    typedef struct packed {
        logic timer_run;
        logic gated_accumulate_enable;
        logic [1:0] clock_divide_select;
        logic external_edge_sync_select;
        logic count_source_select;
    } tcp_ctrl_t;

    typedef enum logic [1:0] {
        TCP_BUS_IDLE = 2'b00,
        TCP_BUS_ACK = 2'b01
    } tcp_bus_st_t;

    // Last prescaler count before an output pulse
    function automatic logic [7:0] tcp_div_last(input logic [1:0] code);
        case (code)
            TCP_DIV_1: tcp_div_last = TCP_LAST_1;
            TCP_DIV_8: tcp_div_last = TCP_LAST_8;
            TCP_DIV_64: tcp_div_last = TCP_LAST_64;
            default: tcp_div_last = TCP_LAST_256;
        endcase
    endfunction : tcp_div_last

    // Byte-enable merge of a 16-bit register
    function automatic logic [15:0] tcp_merge(input logic [15:0] old_v,
                                              input logic [15:0] new_v,
                                              input logic [1:0] be);
        tcp_merge = {be[1] ? new_v[15:8] : old_v[15:8], be[0] ? new_v[7:0] : old_v[7:0]};
    endfunction : tcp_merge
endpackage : tcp_pkg

// >>> design/tcp_edge_sync.sv
// Pin edge detection, raw and through a two-stage synchroniser
`timescale 1ns/1ps
module tcp_edge_sync import tcp_pkg::*; (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic pin_i,
    output logic rise_raw_o,
    output logic rise_sync_o,
    output logic level_sync_o
);
    // ==========================================================
    // State
    typedef struct packed {
        logic raw_prev;
        logic meta;
        logic stable;
        logic stable_prev;
    } tcp_es_t;

    tcp_es_t st_r;
    tcp_es_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.raw_prev = pin_i;
        st_nxt.meta = pin_i;
        st_nxt.stable = st_r.meta;
        st_nxt.stable_prev = st_r.stable;
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Raw path costs no latency but trusts the pin to be clean
    assign rise_raw_o = pin_i & ~st_r.raw_prev;
    assign rise_sync_o = st_r.stable & ~st_r.stable_prev;
    assign level_sync_o = st_r.stable;
endmodule : tcp_edge_sync

// >>> design/tcp_prescaler.sv
// Divide-by-1/8/64/256 prescaler producing one-cycle pulses
`timescale 1ns/1ps
module tcp_prescaler import tcp_pkg::*; #(
    parameter int PS_W = 8
) (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic clear_i,
    input wire logic tick_i,
    input wire logic [1:0] div_sel_i,
    output logic pulse_o
);
    // ==========================================================
    // Elaboration check
    if (PS_W < 8) begin : g_bad_width
        $error("tcp_prescaler: PS_W must hold a count of 255");
    end

    typedef struct packed {
        logic [PS_W-1:0] cnt;
    } tcp_ps_t;

    tcp_ps_t st_r;
    tcp_ps_t st_nxt;
    logic at_last;

    assign at_last = (st_r.cnt[7:0] >= tcp_div_last(div_sel_i));
    assign pulse_o = tick_i & at_last & ~clear_i;

    always_comb begin
        st_nxt = st_r;
        if (clear_i || pulse_o) begin
            st_nxt.cnt = '0;
        end else if (tick_i) begin
            st_nxt.cnt = st_r.cnt + 1'b1;
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ==========================================================
    // Checks
    div256_span_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (pulse_o && div_sel_i == TCP_DIV_256 && $stable(div_sel_i))
        |-> st_r.cnt[7:0] == 8'hFF)
        else $error("divide-by-256 pulse at wrong count");
    div8_span_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (pulse_o && div_sel_i == TCP_DIV_8 && $stable(div_sel_i))
        |-> st_r.cnt[7:0] == 8'h07)
        else $error("divide-by-8 pulse at wrong count");
endmodule : tcp_prescaler

// >>> design/tcp_timer.sv
// Timer with clock-source select, edge sync, gating and prescaler
`timescale 1ns/1ps
module tcp_timer import tcp_pkg::*; #(
    parameter int CNT_W = 16
) (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic timer_ext_clock_pin_i,
    output logic [CNT_W-1:0] timer_count_value_o,
    output logic sync_counter_mode_o
);
    // ==========================================================
    // Elaboration check
    if (CNT_W != 16) begin : g_bad_width
        $error("tcp_timer: the count register is 16 bits wide");
    end

    // ==========================================================
    // State
    typedef struct packed {
        tcp_bus_st_t bus_st;
        tcp_ctrl_t ctrl;
        logic [15:0] count;
        logic [31:0] rdata;
    } tcp_tm_t;

    tcp_tm_t st_r;
    tcp_tm_t st_nxt;

    logic rise_raw;
    logic rise_sync;
    logic gate_level;
    logic tick;
    logic ps_pulse;
    logic sync_mode;
    logic req;
    logic accept;
    logic wr_ctrl;
    logic wr_count;
    logic [15:0] ctrl_view;
    logic [15:0] ctrl_wr;

    // ==========================================================
    // Pin front end and prescaler
    tcp_edge_sync u_edge (
        .mclk_i(mclk_i),
        .rstn_i(rstn_i),
        .pin_i(timer_ext_clock_pin_i),
        .rise_raw_o(rise_raw),
        .rise_sync_o(rise_sync),
        .level_sync_o(gate_level)
    );

    // External source ignores the gate; internal source ignores sync
    always_comb begin
        if (st_r.ctrl.count_source_select) begin
            tick = st_r.ctrl.external_edge_sync_select ? rise_sync : rise_raw;
        end else if (st_r.ctrl.gated_accumulate_enable) begin
            tick = gate_level;
        end else begin
            tick = 1'b1;
        end
    end

    tcp_prescaler #(
        .PS_W(8)
    ) u_ps (
        .mclk_i(mclk_i),
        .rstn_i(rstn_i),
        .clear_i(~st_r.ctrl.timer_run),
        .tick_i(tick),
        .div_sel_i(st_r.ctrl.clock_divide_select),
        .pulse_o(ps_pulse)
    );

    assign sync_mode = st_r.ctrl.count_source_select
                     & st_r.ctrl.external_edge_sync_select
                     & st_r.ctrl.timer_run;

    // ==========================================================
    // Avalon-MM slave: one wait cycle, then the answer
    assign req = avs_read_i | avs_write_i;
    assign accept = req & (st_r.bus_st == TCP_BUS_ACK);
    assign avs_waitrequest_o = req & (st_r.bus_st != TCP_BUS_ACK);
    assign wr_ctrl = accept & avs_write_i & (avs_address_i == TCP_CTRL_OFS);
    assign wr_count = accept & avs_write_i & (avs_address_i == TCP_COUNT_OFS);

    always_comb begin
        ctrl_view = '0;
        ctrl_view[TCP_RUN_BIT] = st_r.ctrl.timer_run;
        ctrl_view[TCP_GATE_BIT] = st_r.ctrl.gated_accumulate_enable;
        ctrl_view[TCP_DIV_LSB +: 2] = st_r.ctrl.clock_divide_select;
        ctrl_view[TCP_SYNC_BIT] = st_r.ctrl.external_edge_sync_select;
        ctrl_view[TCP_SRC_BIT] = st_r.ctrl.count_source_select;
    end

    assign ctrl_wr = tcp_merge(ctrl_view, avs_writedata_i[15:0], avs_byteenable_i[1:0]);

    always_comb begin
        st_nxt = st_r;
        case (st_r.bus_st)
            TCP_BUS_IDLE: begin
                if (req) begin
                    st_nxt.bus_st = TCP_BUS_ACK;
                    // Read data is captured now and stands through the answer edge
                    case (avs_address_i)
                        TCP_CTRL_OFS: st_nxt.rdata = {16'h0000, ctrl_view};
                        TCP_COUNT_OFS: st_nxt.rdata = {16'h0000, st_r.count};
                        TCP_STAT_OFS: st_nxt.rdata = {31'h0, sync_mode};
                        default: st_nxt.rdata = 32'h0000_0000;
                    endcase
                end
            end
            TCP_BUS_ACK: begin
                st_nxt.bus_st = TCP_BUS_IDLE;
            end
            default: begin
                st_nxt.bus_st = TCP_BUS_IDLE;
            end
        endcase

        if (wr_ctrl) begin
            st_nxt.ctrl.timer_run = ctrl_wr[TCP_RUN_BIT];
            st_nxt.ctrl.gated_accumulate_enable = ctrl_wr[TCP_GATE_BIT];
            st_nxt.ctrl.clock_divide_select = ctrl_wr[TCP_DIV_LSB +: 2];
            st_nxt.ctrl.external_edge_sync_select = ctrl_wr[TCP_SYNC_BIT];
            st_nxt.ctrl.count_source_select = ctrl_wr[TCP_SRC_BIT];
        end

        // Outside synchronous counter mode a software write wins over an increment in the same cycle
        if (wr_count && !sync_mode) begin
            st_nxt.count = tcp_merge(st_r.count, avs_writedata_i[15:0],
                                     avs_byteenable_i[1:0]);
        end else if (st_r.ctrl.timer_run && ps_pulse) begin
            st_nxt.count = st_r.count + 16'h0001;
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_r.bus_st <= TCP_BUS_IDLE;
            st_r.ctrl <= tcp_ctrl_t'(6'h00);
            st_r.count <= TCP_COUNT_RESET;
            st_r.rdata <= 32'h0000_0000;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign avs_readdata_o = st_r.rdata;
    assign timer_count_value_o = st_r.count;
    assign sync_counter_mode_o = sync_mode;

    // ==========================================================
    // Checks
    logic [15:0] cnt_plus;
    assign cnt_plus = st_r.count + 16'h0001;

    sync_mode_flag_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        wr_ctrl && ctrl_wr[TCP_RUN_BIT] && ctrl_wr[TCP_SYNC_BIT] && ctrl_wr[TCP_SRC_BIT]
        |=> sync_counter_mode_o)
        else $error("synchronous counter mode not entered");

    write_dropped_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (wr_count && sync_mode) |=>
        (st_r.count == $past(st_r.count) || st_r.count == $past(cnt_plus)))
        else $error("count written in synchronous counter mode");

    write_taken_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (wr_count && !sync_mode && avs_byteenable_i[1:0] == 2'b11)
        |=> st_r.count == $past(avs_writedata_i[15:0]))
        else $error("count write lost outside synchronous counter mode");

    internal_step_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (st_r.ctrl.timer_run && !st_r.ctrl.count_source_select
         && !st_r.ctrl.gated_accumulate_enable
         && st_r.ctrl.clock_divide_select == TCP_DIV_1 && !wr_count && !wr_ctrl)
        |=> st_r.count == $past(cnt_plus))
        else $error("internal clock did not step the count");

    raw_edge_step_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (st_r.ctrl.timer_run && st_r.ctrl.count_source_select
         && !st_r.ctrl.external_edge_sync_select
         && st_r.ctrl.clock_divide_select == TCP_DIV_1 && rise_raw && !wr_count)
        |=> st_r.count == $past(cnt_plus))
        else $error("raw pin edge did not step the count");

    gate_hold_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (st_r.ctrl.timer_run && !st_r.ctrl.count_source_select
         && st_r.ctrl.gated_accumulate_enable && !gate_level && !wr_count)
        |=> $stable(st_r.count))
        else $error("count moved while gate was low");

    stop_hold_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (!st_r.ctrl.timer_run && !wr_count)[*2] |=> $stable(st_r.count))
        else $error("count moved while stopped");

    div8_rate_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (st_r.ctrl.timer_run && ps_pulse && !st_r.ctrl.count_source_select
         && !st_r.ctrl.gated_accumulate_enable
         && st_r.ctrl.clock_divide_select == TCP_DIV_8 && !wr_ctrl)
        |=> !ps_pulse[*7])
        else $error("divide-by-8 pulses too close");

    bus_answer_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        ($rose(req) && st_r.bus_st == TCP_BUS_IDLE) |=> !avs_waitrequest_o)
        else $error("bus answer late");

    ack_once_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (st_r.bus_st == TCP_BUS_ACK) |=> st_r.bus_st == TCP_BUS_IDLE)
        else $error("bus answered twice in a row");

    // Read data is captured a cycle early; nothing may move it before the answer edge
    rdata_hold_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (st_r.bus_st == TCP_BUS_ACK) |=> $stable(avs_readdata_o))
        else $error("read data moved after the answer");

    status_read_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (accept && avs_read_i && avs_address_i == TCP_STAT_OFS)
        |-> avs_readdata_o == {31'h0000_0000, sync_mode})
        else $error("status read disagrees with the mode");

    // ==========================================================
    // Field and mode checks
    gate_bit_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (wr_ctrl && avs_byteenable_i[0])
        |=> ctrl_view[TCP_GATE_BIT] == $past(avs_writedata_i[TCP_GATE_BIT]))
        else $error("gate enable bit not written");

    div_field_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (wr_ctrl && avs_byteenable_i[0])
        |=> st_r.ctrl.clock_divide_select == $past(avs_writedata_i[TCP_DIV_LSB +: 2]))
        else $error("divide code not written");

    mode_off_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (wr_ctrl && !ctrl_wr[TCP_RUN_BIT]) |=> !sync_counter_mode_o)
        else $error("synchronous counter mode kept with run cleared");

    sync_hold_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (sync_mode && !ps_pulse) |=> $stable(st_r.count))
        else $error("count moved in synchronous counter mode without a pulse");

    // ==========================================================
    // Step checks; edge and gate steps only at divide-by-1, pulse_step_a checks the step at every code
    sync_edge_step_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (st_r.ctrl.timer_run && st_r.ctrl.count_source_select
         && st_r.ctrl.external_edge_sync_select
         && st_r.ctrl.clock_divide_select == TCP_DIV_1 && rise_sync && !wr_count)
        |=> st_r.count == $past(cnt_plus))
        else $error("synchronised pin edge did not step the count");

    edge_only_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (st_r.ctrl.timer_run && st_r.ctrl.count_source_select
         && !st_r.ctrl.external_edge_sync_select && !rise_raw && !wr_count)
        |=> $stable(st_r.count))
        else $error("count moved without a raw pin edge");

    gate_count_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (st_r.ctrl.timer_run && !st_r.ctrl.count_source_select
         && st_r.ctrl.gated_accumulate_enable && gate_level
         && st_r.ctrl.clock_divide_select == TCP_DIV_1 && !wr_count)
        |=> st_r.count == $past(cnt_plus))
        else $error("count held while gate was high");

    div1_every_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (st_r.ctrl.timer_run && tick && st_r.ctrl.clock_divide_select == TCP_DIV_1)
        |-> ps_pulse)
        else $error("divide-by-1 missed a tick");

    stop_quiet_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        !st_r.ctrl.timer_run |-> !ps_pulse)
        else $error("prescaler pulsed while stopped");

    pulse_step_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (st_r.ctrl.timer_run && ps_pulse && !wr_count) |=> st_r.count == $past(cnt_plus))
        else $error("prescaler pulse did not step the count");

    count_quiet_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (!ps_pulse && !wr_count) |=> $stable(st_r.count))
        else $error("count moved without pulse or write");

    // ==========================================================
    // Scenario covers

    sync_count_c: cover property (@(posedge mclk_i) disable iff (!rstn_i)
        sync_mode && ps_pulse);
    dropped_write_c: cover property (@(posedge mclk_i) disable iff (!rstn_i)
        wr_count && sync_mode);
    gated_count_c: cover property (@(posedge mclk_i) disable iff (!rstn_i)
        st_r.ctrl.gated_accumulate_enable && !st_r.ctrl.count_source_select && ps_pulse);
    div256_c: cover property (@(posedge mclk_i) disable iff (!rstn_i)
        st_r.ctrl.clock_divide_select == TCP_DIV_256 && ps_pulse);
    raw_edge_c: cover property (@(posedge mclk_i) disable iff (!rstn_i)
        st_r.ctrl.count_source_select && !st_r.ctrl.external_edge_sync_select && ps_pulse);
endmodule : tcp_timer

// >>> test/tcp_pin_src.sv
// External clock source model driving the timer clock pin
`timescale 1ns/1ps
module tcp_pin_src (
    input wire logic mclk_i,
    output logic pin_o
);
    // ==========================================================
    // Pin starts low and keeps its last level outside bursts and holds
    initial pin_o = 1'b0;

    task automatic burst(input int n, input int hi, input int lo);
        repeat (n) begin
            @(posedge mclk_i);
            pin_o <= 1'b1;
            repeat (hi) @(posedge mclk_i);
            pin_o <= 1'b0;
            repeat (lo - 1) @(posedge mclk_i);
        end
    endtask : burst

    task automatic hold(input logic v);
        @(posedge mclk_i);
        pin_o <= v;
    endtask : hold
endmodule : tcp_pin_src

// >>> test/tb.sv
// Self-checking bench for the timer clock-select and prescale block
`timescale 1ns/1ps
module tb import tcp_pkg::*;;
    localparam logic [15:0] RUN = 16'h0001 << TCP_RUN_BIT;
    localparam logic [15:0] GATE = 16'h0001 << TCP_GATE_BIT;
    localparam logic [15:0] SYNC = 16'h0001 << TCP_SYNC_BIT;
    localparam logic [15:0] SRC = 16'h0001 << TCP_SRC_BIT;
    localparam logic [15:0] CMASK = 16'h8076;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [3:0] avs_byteenable = 4'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic pin;
    logic [15:0] cnt;
    logic smode;
    logic [31:0] seed = 32'h0000_0051;
    int n_errors = 0;
    int n_checks = 0;
    int cyc = 0;
    int m_ctrl = 0;
    int dv[4] = '{1, 8, 64, 256};

    always #2.5 mclk = ~mclk;

    tcp_timer #(.CNT_W(16)) DUT (
        .mclk_i(mclk),
        .rstn_i(rstn),
        .avs_address_i(avs_address),
        .avs_read_i(avs_read),
        .avs_write_i(avs_write),
        .avs_writedata_i(avs_writedata),
        .avs_byteenable_i(avs_byteenable),
        .avs_readdata_o(avs_readdata),
        .avs_waitrequest_o(avs_waitrequest),
        .timer_ext_clock_pin_i(pin),
        .timer_count_value_o(cnt),
        .sync_counter_mode_o(smode)
    );

    tcp_pin_src src (
        .mclk_i(mclk),
        .pin_o(pin)
    );

    // ==========================================================
    // Helpers
    function automatic logic [15:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[15:0];
    endfunction : xs

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic close_out();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : close_out

    // Request held until waitrequest is seen low; data taken at that edge
    task automatic bus(input logic wr_en, input logic [3:0] a, input logic [15:0] d,
                       input logic [3:0] be, output logic [31:0] q);
        int lanes;
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= {16'h0000, d};
        avs_byteenable <= be;
        avs_write <= wr_en;
        avs_read <= !wr_en;
        // Sampled in the edge's active step, before the slave's state moves on
        do begin
            @(posedge mclk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        // Control register model: byte lanes merged, unused bits read 0
        lanes = (be[0] ? 32'h0000_00FF : 32'h0000_0000) | (be[1] ? 32'h0000_FF00 : 32'h0000_0000);
        if (wr_en && a == TCP_CTRL_OFS) begin
            m_ctrl = (m_ctrl & ~lanes) | (32'(d) & lanes & 32'(CMASK));
        end else if (!wr_en && a == TCP_CTRL_OFS) begin
            check(q, 32'(m_ctrl));
        end
    endtask : bus

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, 4'hF, q);
    endtask : wr

    task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 16'h0000, 4'hF, q);
        check(q, e);
    endtask : rd_chk

    // Skips a possibly partial first period, then measures a whole one
    task automatic gap(output int n);
        logic [15:0] v;
        int g;
        @(negedge mclk);
        v = cnt;
        g = 0;
        while (cnt === v && g < 600) begin
            @(negedge mclk);
            g++;
        end
        v = cnt;
        n = 0;
        while (cnt === v && n < 600) begin
            @(negedge mclk);
            n++;
        end
        check(32'(cnt), 32'(v + 16'h0001));
    endtask : gap

    always @(posedge mclk) begin
        cyc++;
        if (cyc == 30000) begin
            n_errors++;
            close_out();
        end
    end

    // ==========================================================
    // Main sequence
    initial begin
        int g;
        logic [15:0] r;
        logic [15:0] v;
        logic [31:0] q;
        repeat (8) @(posedge mclk);
        rstn <= 1'b1;
        rd_chk(TCP_CTRL_OFS, {16'h0000, TCP_CTRL_RESET});
        rd_chk(TCP_COUNT_OFS, {16'h0000, TCP_COUNT_RESET});
        wr(4'hC, 16'hFFFF);
        rd_chk(4'hC, 32'h0000_0000);
        rd_chk(TCP_CTRL_OFS, 32'h0000_0000);
        for (int i = 0; i < 4; i++) begin
            r = xs() & ~RUN;
            wr(TCP_CTRL_OFS, r);
            rd_chk(TCP_CTRL_OFS, {16'h0000, r & CMASK});
        end
        wr(TCP_CTRL_OFS, 16'h0000);
        bus(1'b1, TCP_CTRL_OFS, 16'hFFFF, 4'h1, q);
        rd_chk(TCP_CTRL_OFS, 32'h0000_0076);
        // ==========================================================
        // Internal clock through every divide code, sync bit ignored
        for (int k = 0; k < 4; k++) begin
            wr(TCP_CTRL_OFS, RUN | SYNC | (16'(k) << TCP_DIV_LSB));
            gap(g);
            check(32'(g), 32'(dv[k]));
        end
        wr(TCP_CTRL_OFS, 16'h0000);
        @(negedge mclk);
        v = cnt;
        repeat (20) @(negedge mclk);
        check(32'(cnt), 32'(v));
        // ==========================================================
        // Pin edges, raw and synchronised, then divided by eight
        r = xs();
        wr(TCP_COUNT_OFS, r);
        wr(TCP_CTRL_OFS, RUN | SRC);
        src.burst(5, 1, 1);
        repeat (8) @(negedge mclk);
        check(32'(cnt), 32'(r + 16'h0005));
        wr(TCP_CTRL_OFS, RUN | SRC | SYNC);
        src.burst(7, 3, 4);
        repeat (8) @(negedge mclk);
        check(32'(cnt), 32'(r + 16'h000C));
        wr(TCP_CTRL_OFS, 16'h0000);
        v = cnt;
        wr(TCP_CTRL_OFS, RUN | SRC | SYNC | (16'h0001 << TCP_DIV_LSB));
        src.burst(16, 2, 2);
        repeat (8) @(negedge mclk);
        check(32'(cnt), 32'(v + 16'h0002));
        // ==========================================================
        // Every source/sync/run mix: mode flag; count write blocking in all but the two running internal-source mixes
        for (int k = 0; k < 8; k++) begin
            wr(TCP_CTRL_OFS, (k[2] ? RUN : 16'h0000) | (k[1] ? SYNC : 16'h0000)
                | (k[0] ? SRC : 16'h0000));
            rd_chk(TCP_STAT_OFS, {31'h0000_0000, k == 7});
            check(32'(smode), 32'(k == 7));
            if (k[0] || !k[2]) begin
                @(negedge mclk);
                v = cnt;
                r = xs();
                wr(TCP_COUNT_OFS, r);
                rd_chk(TCP_COUNT_OFS, {16'h0000, (k == 7) ? v : r});
            end
        end
        // ==========================================================
        // Gated accumulation counts clocks only while the pin is high
        wr(TCP_CTRL_OFS, 16'h0000);
        wr(TCP_COUNT_OFS, 16'h0000);
        wr(TCP_CTRL_OFS, RUN | GATE);
        repeat (10) @(negedge mclk);
        check(32'(cnt), 32'h0000_0000);
        src.hold(1'b1);
        repeat (19) @(posedge mclk);
        src.hold(1'b0);
        repeat (8) @(negedge mclk);
        check(32'(cnt), 32'h0000_0014);
        close_out();
    end
endmodule : tb
